// [design/host_bus_mode_select.sv]
// Strap-selected host bus front end with clock source and master select
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
module host_bus_mode_select
(
   input wire logic clk,
   input wire logic rst,
   input wire logic chip_select_low_active_n,
   input wire logic chip_select_high_active,
   input wire logic host_protocol_select,
   input wire logic parallel_select,
   input wire logic oscillator_source_select,
   input wire logic master_select,
   input wire logic read_enable_strobe,
   input wire logic write_dir_strobe,
   input wire logic data_cmd_select,
   input wire logic [7:0] data_in,
   input wire logic display_timing_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic [7:0] wr_data,
   output logic wr_is_data,
   output logic wr_valid,
   output logic rd_req,
   output logic display_timing_out,
   output logic display_timing_oe,
   output logic display_clock
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic wr_prev_q;
   logic wr_prev_d;
   logic rd_prev_q;
   logic rd_prev_d;
   logic en_prev_q;
   logic en_prev_d;
   logic [7:0] wr_data_q;
   logic [7:0] wr_data_d;
   logic wr_is_data_q;
   logic wr_is_data_d;
   logic wr_valid_q;
   logic wr_valid_d;
   logic rd_req_q;
   logic rd_req_d;
   logic data_oe_q;
   logic data_oe_d;
   logic [2:0] div_q;
   logic [2:0] div_d;
   logic osc_q;
   logic osc_d;
   logic tim_out_q;
   logic tim_out_d;
   logic tim_oe_q;
   logic tim_oe_d;
   logic dclk_q;
   logic dclk_d;
   logic sel;
   logic par;
   logic wr_rise;
   logic rd_rise;
   logic en_fall;
   logic take_write;
   logic drive_timing;

   // ----------------------------------------
   // Select and strobe edges
   // ----------------------------------------
   always_comb
   begin
      sel = ~chip_select_low_active_n & chip_select_high_active;
      par = parallel_select;
      // 8080 write strobe, low while active
      wr_rise = ~wr_prev_q & write_dir_strobe;
      // 8080 read strobe, low while active
      rd_rise = ~rd_prev_q & read_enable_strobe;
      // 6800 enable, high while active
      en_fall = en_prev_q & ~read_enable_strobe;
      wr_prev_d = write_dir_strobe;
      rd_prev_d = read_enable_strobe;
      en_prev_d = read_enable_strobe;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         // Idle levels, so no false edge follows reset
         wr_prev_q <= 1'b1;
         rd_prev_q <= 1'b1;
         en_prev_q <= 1'b0;
      end
      else
      begin
         wr_prev_q <= wr_prev_d;
         rd_prev_q <= rd_prev_d;
         en_prev_q <= en_prev_d;
      end
   end

   // ----------------------------------------
   // Host transfers
   // ----------------------------------------
   always_comb
   begin
      wr_data_d = wr_data_q;
      wr_is_data_d = wr_is_data_q;
      take_write = 1'b0;
      rd_req_d = 1'b0;
      data_oe_d = 1'b0;
      if (sel && par)
      begin
         if (host_protocol_select)
         begin
            // Direction high reads, low writes, taken on enable fall
            data_oe_d = read_enable_strobe & write_dir_strobe;
            take_write = en_fall & ~write_dir_strobe;
            rd_req_d = en_fall & write_dir_strobe;
         end
         else
         begin
            data_oe_d = ~read_enable_strobe;
            take_write = wr_rise;
            rd_req_d = rd_rise;
         end
      end
      if (take_write)
      begin
         wr_data_d = data_in;
         wr_is_data_d = data_cmd_select;
      end
      wr_valid_d = take_write;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_data_q <= host_bus_pkg::DATA_RST;
         wr_is_data_q <= 1'b0;
         wr_valid_q <= 1'b0;
         rd_req_q <= 1'b0;
         data_oe_q <= 1'b0;
      end
      else
      begin
         wr_data_q <= wr_data_d;
         wr_is_data_q <= wr_is_data_d;
         wr_valid_q <= wr_valid_d;
         rd_req_q <= rd_req_d;
         data_oe_q <= data_oe_d;
      end
   end

   // ----------------------------------------
   // Internal oscillator
   // ----------------------------------------
   always_comb
   begin
      div_d = div_q;
      osc_d = osc_q;
      if (oscillator_source_select)
      begin
         if (div_q == host_bus_pkg::DIV_LAST)
         begin
            div_d = host_bus_pkg::DIV_RST;
            osc_d = ~osc_q;
         end
         else
         begin
            div_d = div_q + 3'h1;
         end
      end
      else
      begin
         // Stopped while the clock comes from outside
         div_d = host_bus_pkg::DIV_RST;
         osc_d = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         div_q <= host_bus_pkg::DIV_RST;
         osc_q <= 1'b0;
      end
      else
      begin
         div_q <= div_d;
         osc_q <= osc_d;
      end
   end

   // ----------------------------------------
   // Display timing pin and clock
   // ----------------------------------------
   always_comb
   begin
      // Master with internal clock drives the timing pin
      drive_timing = master_select & oscillator_source_select;
      tim_oe_d = drive_timing;
      tim_out_d = osc_q;
      // Otherwise the display clock comes in on the timing pin
      dclk_d = drive_timing ? osc_q : display_timing_in;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tim_out_q <= 1'b0;
         tim_oe_q <= 1'b0;
         dclk_q <= 1'b0;
      end
      else
      begin
         tim_out_q <= tim_out_d;
         tim_oe_q <= tim_oe_d;
         dclk_q <= dclk_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------

   assign wr_data = wr_data_q;
   assign wr_is_data = wr_is_data_q;
   assign wr_valid = wr_valid_q;
   assign rd_req = rd_req_q;
   assign data_oe = data_oe_q;
   assign data_out = wr_data_q;
   assign display_timing_out = tim_out_q;
   assign display_timing_oe = tim_oe_q;
   assign display_clock = dclk_q;
endmodule : host_bus_mode_select

// [shared/host_bus_pkg.sv]
// Constants for the strap-selected host bus front end
// Overview of operation
// - Capture data on write strobe rising edge (8080) or enable falling edge with direction low (6800)
// - Direction pin high reads, low writes
// - Width strap high parallel, low serial, where no host transfer or read request is taken
// - Oscillator strap low takes external clock
// - Master with internal clock drives timing, otherwise it is taken
package host_bus_pkg;
   // ----------------------------------------
   // Widths, reset values and divider last count
   // ----------------------------------------
   localparam int DATA_W = 8;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [2:0] DIV_RST = 3'h0;
   localparam logic [2:0] DIV_LAST = 3'h3;
endpackage : host_bus_pkg

// [sim/host_bus_asserts.sv]
// Checker for the host bus front end
`timescale 1ns/100ps
module host_bus_chk
(
   input wire logic clk,
   input wire logic rst,
   input wire logic chip_select_low_active_n,
   input wire logic chip_select_high_active,
   input wire logic host_protocol_select,
   input wire logic parallel_select,
   input wire logic oscillator_source_select,
   input wire logic master_select,
   input wire logic read_enable_strobe,
   input wire logic write_dir_strobe,
   input wire logic [7:0] data_in,
   input wire logic display_timing_in,
   input wire logic [7:0] wr_data,
   input wire logic wr_valid,
   input wire logic rd_req,
   input wire logic display_timing_oe,
   input wire logic display_clock
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire sel = !chip_select_low_active_n & chip_select_high_active
      & parallel_select;
   wire m68 = host_protocol_select;
   a_wr_capture: assert property (sel & !m68 & $rose(write_dir_strobe)
      |=> wr_valid & wr_data == $past(data_in)) else $error("no write");
   a_strobe_read: assert property (sel & !m68
      & $rose(read_enable_strobe) |=> rd_req & !wr_valid)
      else $error("no read");
   a_rw_read: assert property (sel & m68 & $fell(read_enable_strobe)
      & write_dir_strobe |=> rd_req & !wr_valid) else $error("no read");
   a_rw_write: assert property (sel & m68 & $fell(read_enable_strobe)
      & !write_dir_strobe |=> wr_valid & !rd_req) else $error("no write");
   a_serial_idle: assert property (!parallel_select
      |=> !wr_valid & !rd_req) else $error("serial taken");
   a_ext_clock: assert property (!$past(oscillator_source_select)
      & !$past(rst) |-> display_clock == $past(display_timing_in))
      else $error("clock source");
   a_master_oe: assert property (!$past(rst) |-> display_timing_oe ==
      ($past(master_select) & $past(oscillator_source_select)))
      else $error("timing drive");
endmodule : host_bus_chk
bind host_bus_mode_select host_bus_chk chk_u (.*);

// [sim/mpu_model.sv]
// Host processor model issuing 8080 or 6800 bus cycles
`timescale 1ns/100ps
module mpu_model
(
   input wire logic clk,
   input wire logic m6800,
   output logic rd_e = 1'b1,
   output logic wr_rw = 1'b1,
   output logic [7:0] d = 8'h00
);
   task automatic xfer(input logic rd, input logic [7:0] v);
      @(posedge clk);
      d <= v;
      if (m6800)
      begin
         wr_rw <= rd;
         rd_e <= 1'b1;
      end
      else if (rd)
         rd_e <= 1'b0;
      else
         wr_rw <= 1'b0;
      @(posedge clk);
      rd_e <= !m6800;
      @(posedge clk);
      wr_rw <= 1'b1;
      repeat (3) @(posedge clk);
      d <= ~v;
   endtask : xfer
endmodule : mpu_model

// [sim/test_host_bus_mode_select.sv]
// Self-checking bench for the host bus front end
`timescale 1ns/100ps
module test_host_bus_mode_select;
   logic clk = 0, rst = 1, csn = 0, m68 = 0, par = 1, osc = 1, ms = 1;
   logic ext = 0, rde, wrw, vld, rdq, toe, dclk, dc = 0, wid, tout;
   logic [7:0] d, wd, dout, last = 8'h00;
   int mismatches, n_checks, cyc, n_wr, n_rd, ew, er;
   host_bus_mode_select dut_u (.clk, .rst, .chip_select_low_active_n(csn),
      .chip_select_high_active(1'b1), .host_protocol_select(m68),
      .parallel_select(par), .oscillator_source_select(osc),
      .master_select(ms), .read_enable_strobe(rde), .write_dir_strobe(wrw),
      .data_cmd_select(dc), .data_in(d), .display_timing_in(ext),
      .data_out(dout), .data_oe(), .wr_data(wd), .wr_is_data(wid),
      .wr_valid(vld), .rd_req(rdq), .display_timing_out(tout),
      .display_timing_oe(toe),
      .display_clock(dclk));
   mpu_model mpu_u (.clk, .m6800(m68), .rd_e(rde), .wr_rw(wrw), .d);
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      n_wr <= n_wr + vld;
      n_rd <= n_rd + rdq;
      ext <= ~ext;
      cyc <= cyc + 1;
      if (cyc > 3000)
      begin
         mismatches++;
         test_done;
      end
   end
   task chk(input logic [7:0] s, e);
      n_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("unexpected at %0t: %h not %h", $time, s, e);
      end
   endtask : chk
   task op(input logic rd, input logic [7:0] v, input int w, r);
      dc <= v[0];
      mpu_u.xfer(rd, v);
      @(negedge clk);
      ew += w;
      er += r;
      if (w)
         last = v;
      chk(wd, last);
      chk(dout, last);
      chk({7'h00, wid}, {7'h00, last[0]});
      chk(8'(n_wr), 8'(ew));
      chk(8'(n_rd), 8'(er));
   endtask : op
   task st(input logic o, m, e);
      @(posedge clk);
      {osc, ms} <= {o, m};
      repeat (3) @(negedge clk);
      chk({7'h00, toe}, {7'h00, e});
      if (!e)
         chk({7'h00, dclk}, {7'h00, ~ext});
      else
         chk({7'h00, dclk}, {7'h00, tout});
   endtask : st
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 0;
      op(0, 8'ha5, 1, 0);
      op(1, 8'h00, 0, 1);
      @(posedge clk) csn <= 1;
      op(0, 8'h11, 0, 0);
      @(posedge clk) {csn, par} <= 2'h0;
      op(0, 8'h22, 0, 0);
      @(posedge clk) {par, m68} <= 2'h3;
      op(1, 8'h00, 0, 1);
      op(0, 8'h3c, 1, 0);
      st(0, 1, 0);
      st(1, 1, 1);
      st(1, 0, 0);
      test_done;
   end
endmodule : test_host_bus_mode_select
